// ==== core/serial_channel.sv ====
// serial_channel: one asynchronous channel with its host bus, generator and buffer
// assumes bus pins and clock pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t s;
  fifo_st_t next_s;
  logic push;
  logic pop;

  // depth need not be a power of two
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign in_ready_o = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rp];

  always_comb begin
    next_s = s;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = nxt(s.wp);
    end
    if (pop) begin
      next_s.rp = nxt(s.rp);
    end
    case ({push, pop})
      2'b10: next_s.cnt = s.cnt + 1'b1;
      2'b01: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
    if (flush_i) begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : tx_fifo

module serial_channel
  import serial_channel_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // host bus, strobes active low
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic data_sel_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // interrupt
  input wire logic chain_enable_in_i,
  output logic irq_n_o,
  // serial line
  input wire logic rxd_i,
  output logic txd_o,
  // clock pins
  input wire logic receive_clock_pin_i,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe_o
);
  typedef struct packed {
    logic [15:0][7:0] wr;
    logic [3:0] ptr;
    logic cs_s1, cs_s2, rd_s1, rd_s2, rd_q;
    logic wr_s1, wr_s2, wr_q, dc_s1, dc_s2;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic rc_s1, rc_s2, rc_q, tc_s1, tc_s2, tc_q;
    logic rx_s1, rx_s2, ie_s1, ie_s2;
    logic [16:0] gcnt;
    logic gout;
    tx_state_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_n;
    logic [7:0] tx_t;
    logic tx_line, tx_par, tx_ip;
    rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_n;
    logic [7:0] rx_t;
    logic [7:0] rx_hold;
    logic rx_par, rx_avail, e_par, e_ovr, e_frm;
    logic [7:0] dout;
    logic doe, irq_n, txd, clk_out, clk_out_oe;
  } st_t;

  // strobes idle high so release does not look like a pin reset
  localparam st_t RST_ST = '{tx_st: T_IDLE, rx_st: R_IDLE, tx_line: 1'b1, txd: 1'b1,
    irq_n: 1'b1, cs_s1: 1'b1, cs_s2: 1'b1, rd_s1: 1'b1, rd_s2: 1'b1, wr_s1: 1'b1,
    wr_s2: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, default: '0};

  st_t s;
  st_t next_s;
  logic rd_act, wr_act, hw_rst, soft_rst, rst_any;
  logic rd_fall, wr_fall, ctl_wr, gen_en, src_edge, g_rise;
  logic rc_edge, tc_edge, tx_tick, rx_tick, tx_end, rx_end, rx_line;
  logic loop, par_en, even, ip_rx, ip_spec, ip_tx;
  logic f_push, f_pop, f_ready, f_valid;
  logic [7:0] f_data;
  logic [16:0] reload;
  logic [7:0] tpb, stp, hmid, stat0, rr1, vec_st;
  logic [3:0] nbt, nbr;
  logic [2:0] code;

  tx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .flush_i(rst_any),
    .in_valid_i(f_push),
    .in_ready_o(f_ready),
    .in_data_i(s.d_s2),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  always_comb begin
    next_s = s;
    next_s.cs_s1 = cs_n_i;
    next_s.cs_s2 = s.cs_s1;
    next_s.rd_s1 = rd_n_i;
    next_s.rd_s2 = s.rd_s1;
    next_s.wr_s1 = wr_n_i;
    next_s.wr_s2 = s.wr_s1;
    next_s.dc_s1 = data_sel_i;
    next_s.dc_s2 = s.dc_s1;
    next_s.d_s1 = data_i;
    next_s.d_s2 = s.d_s1;
    next_s.rc_s1 = receive_clock_pin_i;
    next_s.rc_s2 = s.rc_s1;
    next_s.rc_q = s.rc_s2;
    next_s.tc_s1 = transmit_clock_pin_i;
    next_s.tc_s2 = s.tc_s1;
    next_s.tc_q = s.tc_s2;
    next_s.rx_s1 = rxd_i;
    next_s.rx_s2 = s.rx_s1;
    next_s.ie_s1 = chain_enable_in_i;
    next_s.ie_s2 = s.ie_s1;
    rc_edge = s.rc_s2 && !s.rc_q;
    tc_edge = s.tc_s2 && !s.tc_q;
    // bus decode; both strobes low together is the reset pin
    hw_rst = !s.rd_s2 && !s.wr_s2;
    rd_act = !s.rd_s2 && !s.cs_s2;
    wr_act = !s.wr_s2 && !s.cs_s2;
    next_s.rd_q = rd_act;
    next_s.wr_q = wr_act;
    rd_fall = rd_act && !s.rd_q && !hw_rst;
    wr_fall = wr_act && !s.wr_q && !hw_rst;
    ctl_wr = wr_fall && !s.dc_s2;
    f_push = wr_fall && s.dc_s2;
    // RL7 force reset command
    soft_rst = ctl_wr && (s.ptr == A_MIRQ) && (s.d_s2[7:6] == FORCE_RST);
    rst_any = hw_rst || soft_rst;
    loop = s.wr[A_GEN][B_LOOP];
    par_en = s.wr[A_MODE][B_PAREN];
    even = s.wr[A_MODE][B_EVEN];
    // RL1 RL3 generator reload
    reload = {1'b0, s.wr[A_DIVH], s.wr[A_DIVL]} + DIV_ADJ;
    gen_en = s.wr[A_GEN][B_GENEN];
    src_edge = s.wr[A_GEN][B_GENSRC] ? 1'b1 : rc_edge;
    g_rise = 1'b0;
    // RL8 RL19 generator run and hold
    if (!gen_en) begin
      next_s.gcnt = reload;
    end else if (src_edge) begin
      if (s.gcnt <= 17'h00001) begin
        next_s.gcnt = reload;
        next_s.gout = !s.gout;
        g_rise = !s.gout;
      end else begin
        next_s.gcnt = s.gcnt - 17'h00001;
      end
    end
    // RL18 clock routing; pin output only carries the generator
    tx_tick = clk_tick(s.wr[A_CLK][4:3], rc_edge, tc_edge, g_rise);
    rx_tick = clk_tick(s.wr[A_CLK][6:5], rc_edge, tc_edge, g_rise);
    next_s.clk_out = next_s.gout;
    next_s.clk_out_oe = s.wr[A_CLK][B_TRXOE];
    // RL13 RL20 ticks per bit and stop length
    tpb = ticks_per_bit(s.wr[A_MODE][7:6]);
    stp = stop_ticks(s.wr[A_MODE][3:2], tpb);
    hmid = (tpb >> 1) - {7'h00, (tpb != TPB_X1)};
    nbt = char_bits(s.wr[A_TXP][6:5]);
    nbr = char_bits(s.wr[A_RXP][7:6]);
    // host reads; data read frees the holding register
    next_s.doe = rd_act && !hw_rst;
    ip_spec = (s.e_par || s.e_ovr || s.e_frm) && (s.wr[A_IE][4:3] != NO_IRQ_MODE);
    ip_rx = s.rx_avail && (s.wr[A_IE][4:3] != NO_IRQ_MODE);
    ip_tx = s.tx_ip && s.wr[A_IE][B_TXIE];
    // RL12 status merged into vector
    code = ip_spec ? ST_SPEC : (ip_rx ? ST_RX : (ip_tx ? ST_TX : ST_NONE));
    vec_st = s.wr[A_VBASE];
    if (s.wr[A_MIRQ][B_STHI]) begin
      vec_st[6:4] = code;
    end else begin
      vec_st[3:1] = code;
    end
    // RL24 polled status
    stat0 = '0;
    stat0[STAT_RXA] = s.rx_avail;
    stat0[STAT_TBE] = f_ready;
    rr1 = '0;
    rr1[RR1_SENT] = !f_valid && (s.tx_st == T_IDLE);
    rr1[RR1_PAR] = s.e_par;
    rr1[RR1_OVR] = s.e_ovr;
    rr1[RR1_FRM] = s.e_frm;
    if (rd_fall) begin
      if (s.dc_s2) begin
        next_s.dout = s.rx_hold;
        next_s.rx_avail = 1'b0;
      end else begin
        next_s.ptr = '0;
        case (s.ptr)
          A_STATUS: next_s.dout = stat0;
          A_ERRS: next_s.dout = rr1;
          A_VECTOR: next_s.dout = vec_st;
          default: next_s.dout = IDLE_BUS;
        endcase
      end
    end
    // control writes: pointer and commands first, then the register
    if (ctl_wr) begin
      if (s.ptr == A_STATUS) begin
        next_s.wr[0] = s.d_s2;
        next_s.ptr = {(s.d_s2[5:3] == CMD_PHI), s.d_s2[2:0]};
        if (s.d_s2[5:3] == CMD_TXIP) begin
          next_s.tx_ip = 1'b0;
        end
        if (s.d_s2[5:3] == CMD_ERR) begin
          next_s.e_par = 1'b0;
          next_s.e_ovr = 1'b0;
          next_s.e_frm = 1'b0;
        end
      end else begin
        next_s.wr[s.ptr] = s.d_s2;
        next_s.ptr = '0;
      end
    end
    // transmitter; set of tx pending comes after its clear
    f_pop = 1'b0;
    tx_end = (s.tx_st == T_STOP) ? (s.tx_t == stp - 8'h01) : (s.tx_t == tpb - 8'h01);
    if (tx_tick && (s.tx_st != T_IDLE)) begin
      next_s.tx_t = tx_end ? 8'h00 : s.tx_t + 8'h01;
    end
    case (s.tx_st)
      T_IDLE: begin
        next_s.tx_line = 1'b1;
        // RL10 enable gates new characters
        if (s.wr[A_TXP][B_TXEN] && f_valid) begin
          f_pop = 1'b1;
          next_s.tx_sh = f_data;
          next_s.tx_n = '0;
          next_s.tx_t = '0;
          next_s.tx_par = 1'b0;
          next_s.tx_line = 1'b0;
          next_s.tx_st = T_START;
          next_s.tx_ip = 1'b1;
        end
      end
      T_START: begin
        if (tx_tick && tx_end) begin
          next_s.tx_st = T_DATA;
          next_s.tx_line = s.tx_sh[0];
        end
      end
      T_DATA: begin
        // RL14 shift out lsb first
        if (tx_tick && tx_end) begin
          next_s.tx_par = s.tx_par ^ s.tx_sh[0];
          next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
          next_s.tx_n = s.tx_n + 4'h1;
          next_s.tx_line = s.tx_sh[1];
          if (s.tx_n == nbt - 4'h1) begin
            next_s.tx_st = par_en ? T_PAR : T_STOP;
            next_s.tx_line = par_en ? (s.tx_par ^ s.tx_sh[0] ^ !even) : 1'b1;
          end
        end
      end
      T_PAR: begin
        if (tx_tick && tx_end) begin
          next_s.tx_st = T_STOP;
          next_s.tx_line = 1'b1;
        end
      end
      T_STOP: begin
        if (tx_tick && tx_end) begin
          next_s.tx_st = T_IDLE;
        end
      end
      default: next_s.tx_st = T_IDLE;
    endcase
    // RL22 loopback feeds receiver, pin held at mark
    rx_line = loop ? s.tx_line : s.rx_s2;
    next_s.txd = loop ? 1'b1 : next_s.tx_line;
    // RL17 level coding only, sampled at bit centre
    rx_end = (s.rx_t == tpb - 8'h01);
    if (rx_tick && (s.rx_st != R_IDLE)) begin
      next_s.rx_t = s.rx_t + 8'h01;
    end
    // RL9 receiver enable
    if (!s.wr[A_RXP][B_RXEN]) begin
      next_s.rx_st = R_IDLE;
    end else begin
      case (s.rx_st)
        R_IDLE: begin
          if (rx_tick && !rx_line) begin
            next_s.rx_st = R_START;
            next_s.rx_t = '0;
          end
        end
        R_START: begin
          if (rx_tick && (s.rx_t >= hmid)) begin
            next_s.rx_t = '0;
            next_s.rx_n = '0;
            next_s.rx_par = 1'b0;
            // a glitch that ends before mid bit is no start
            next_s.rx_st = rx_line ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_tick && rx_end) begin
            next_s.rx_t = '0;
            next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
            next_s.rx_par = s.rx_par ^ rx_line;
            next_s.rx_n = s.rx_n + 4'h1;
            if (s.rx_n == nbr - 4'h1) begin
              next_s.rx_st = par_en ? R_PAR : R_STOP;
            end
          end
        end
        R_PAR: begin
          if (rx_tick && rx_end) begin
            next_s.rx_t = '0;
            next_s.rx_st = R_STOP;
            if ((s.rx_par ^ rx_line) == even) begin
              next_s.e_par = 1'b1;
            end
          end
        end
        R_STOP: begin
          if (rx_tick && rx_end) begin
            next_s.rx_st = R_IDLE;
            next_s.rx_hold = s.rx_sh >> (4'h8 - nbr);
            next_s.rx_avail = 1'b1;
            // unread character is overwritten, flagged as overrun
            if (s.rx_avail) begin
              next_s.e_ovr = 1'b1;
            end
            if (!rx_line) begin
              next_s.e_frm = 1'b1;
            end
          end
        end
        default: next_s.rx_st = R_IDLE;
      endcase
    end
    // RL15 RL16 RL23 interrupt request
    next_s.irq_n = !(s.wr[A_MIRQ][B_MASTER_EN] && s.ie_s2 && (ip_spec || ip_rx || ip_tx));
    // RL7 RL11 reset leaves buffers empty
    if (rst_any) begin
      next_s.wr = {16{CFG_RST}};
      next_s.ptr = '0;
      next_s.gcnt = '0;
      next_s.gout = 1'b0;
      next_s.clk_out = 1'b0;
      next_s.clk_out_oe = 1'b0;
      next_s.tx_st = T_IDLE;
      next_s.tx_line = 1'b1;
      next_s.txd = 1'b1;
      next_s.tx_ip = 1'b0;
      next_s.rx_st = R_IDLE;
      next_s.rx_avail = 1'b0;
      next_s.e_par = 1'b0;
      next_s.e_ovr = 1'b0;
      next_s.e_frm = 1'b0;
      next_s.irq_n = 1'b1;
      next_s.dout = IDLE_BUS;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= RST_ST;
    end else begin
      s <= next_s;
    end
  end

  assign data_o = s.dout;
  assign data_oe_o = s.doe;
  assign irq_n_o = s.irq_n;
  assign txd_o = s.txd;
  assign transmit_clock_pin_o = s.clk_out;
  assign transmit_clock_pin_oe_o = s.clk_out_oe;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_force;
    ctl_wr && (s.ptr == A_MIRQ) && (s.d_s2[7:6] == FORCE_RST);
  endsequence
  sequence s_load;
    f_pop && !rst_any ##1 (s.tx_st == T_START);
  endsequence

  property p_force;
    s_force |=> (s.wr == {16{CFG_RST}}) && !s.rx_avail && (s.tx_st == T_IDLE) && irq_n_o;
  endproperty
  a_force: assert property (p_force) else $error("force reset left state"); // RL7
  property p_master_off;
    !s.wr[A_MIRQ][B_MASTER_EN] |=> irq_n_o;
  endproperty
  a_master_off: assert property (p_master_off) else $error("irq without master enable"); // RL16
  property p_irq_rx;
    s.wr[A_MIRQ][B_MASTER_EN] && s.ie_s2 && s.rx_avail && (s.wr[A_IE][4:3] != NO_IRQ_MODE) && !rst_any
      |=> !irq_n_o;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("pending rx gave no irq"); // RL23
  property p_txip;
    f_pop && !rst_any |=> s.tx_ip;
  endproperty
  a_txip: assert property (p_txip) else $error("tx pending not set on load"); // RL15
  property p_start;
    s_load |-> !s.tx_line && (txd_o == loop);
  endproperty
  a_start: assert property (p_start) else $error("start bit missing"); // RL14
  property p_lsb;
    (s.tx_st == T_START) && tx_tick && tx_end && !rst_any |=> s.tx_line == $past(s.tx_sh[0]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("first data bit not lsb"); // RL14
  property p_gen_hold;
    !gen_en |=> $stable(s.gout) || $past(rst_any);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("stopped generator toggled"); // RL8
  property p_gen_reload;
    gen_en && src_edge && (s.gcnt <= 17'h00001) && !rst_any |=> (s.gcnt == $past(reload)) && (s.gout != $past(s.gout));
  endproperty
  a_gen_reload: assert property (p_gen_reload) else $error("generator reload wrong"); // RL1
  property p_rx_off;
    !s.wr[A_RXP][B_RXEN] |=> s.rx_st == R_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("disabled receiver ran"); // RL9
  property p_tx_off;
    !s.wr[A_TXP][B_TXEN] && (s.tx_st == T_IDLE) |=> s.tx_st == T_IDLE;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("disabled transmitter started"); // RL10
  property p_loop;
    loop && !rst_any |=> txd_o;
  endproperty
  a_loop: assert property (p_loop) else $error("line driven in loopback"); // RL22
  property p_vec;
    rd_fall && !s.dc_s2 && (s.ptr == A_VECTOR) |=> data_o == $past(vec_st);
  endproperty
  a_vec: assert property (p_vec) else $error("vector read mismatch"); // RL12
  property p_empty;
    rst_any |=> f_ready && !f_valid && !s.rx_avail;
  endproperty
  a_empty: assert property (p_empty) else $error("buffers not empty after reset"); // RL11
endmodule : serial_channel

`default_nettype wire

// ==== core/serial_channel_pkg.sv ====
// serial_channel_pkg: register map, field positions, reset values, codes
// assumes one asynchronous channel behind an 8-bit strobed host bus
// How it works
// RL1 - generator half period is time constant plus two source edges
// RL2 - host picks the divider from the rate set for its source clock
// RL3 - time constant is sixteen bits held in a low and a high byte
// RL4 - host keeps the bit rate under a quarter of the system clock
// RL5 - host leaves six clocks between two bus accesses
// RL6 - host leaves eleven clocks after any reset before the next access
// RL7 - force-reset command in the master register acts as the reset pin
// RL8 - generator runs while its enable bit is set
// RL9 - receiver runs while its enable bit is set
// RL10 - transmitter takes characters only while its enable bit is set
// RL11 - after reset the transmit buffer and receive holding are empty
// RL12 - vector read returns the base vector with status code merged in
// RL13 - x16 mode uses sixteen clock ticks per serial bit
// RL14 - eight-bit characters go out whole, least significant bit first
// RL15 - enable value 12H gives receive-every-character and transmit interrupts
// RL16 - master enable clear keeps the interrupt output idle
// RL17 - coding value 00H means plain level coding both ways
// RL18 - clock value 56H clocks both sides from the generator and drives it out
// RL19 - misc value 10H picks pin source, generator stopped, loopback
// RL20 - mode value 4CH gives async, x16, two stop bits, no parity
// RL21 - host programs formats disabled first, then enables both directions
// RL22 - loopback feeds the transmit line into the receiver internally
// RL23 - master enable lets pending conditions drive the interrupt output
// RL24 - primary status shows transmit room and receive character ready
package serial_channel_pkg;
  // write register pointers
  localparam logic [3:0] A_IE = 4'h1;
  localparam logic [3:0] A_VBASE = 4'h2;
  localparam logic [3:0] A_RXP = 4'h3;
  localparam logic [3:0] A_MODE = 4'h4;
  localparam logic [3:0] A_TXP = 4'h5;
  localparam logic [3:0] A_MIRQ = 4'h9;
  localparam logic [3:0] A_CODE = 4'hA;
  localparam logic [3:0] A_CLK = 4'hB;
  localparam logic [3:0] A_DIVL = 4'hC;
  localparam logic [3:0] A_DIVH = 4'hD;
  localparam logic [3:0] A_GEN = 4'hE;
  // read register pointers
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_ERRS = 4'h1;
  localparam logic [3:0] A_VECTOR = 4'h2;
  // bit positions
  localparam int B_RXEN = 0;
  localparam int B_TXEN = 3;
  localparam int B_GENEN = 0;
  localparam int B_GENSRC = 1;
  localparam int B_LOOP = 4;
  localparam int B_MASTER_EN = 3;
  localparam int B_STHI = 4;
  localparam int B_TXIE = 1;
  localparam int B_TRXOE = 2;
  localparam int B_EVEN = 1;
  localparam int B_PAREN = 0;
  localparam int STAT_RXA = 0;
  localparam int STAT_TBE = 2;
  localparam int RR1_SENT = 0;
  localparam int RR1_PAR = 4;
  localparam int RR1_OVR = 5;
  localparam int RR1_FRM = 6;
  // command and select codes
  localparam logic [1:0] FORCE_RST = 2'h3;
  localparam logic [2:0] CMD_PHI = 3'h1;
  localparam logic [2:0] CMD_TXIP = 3'h5;
  localparam logic [2:0] CMD_ERR = 3'h6;
  localparam logic [1:0] CLK_PIN = 2'h0;
  localparam logic [1:0] CLK_TRX = 2'h1;
  localparam logic [1:0] NO_IRQ_MODE = 2'h0;
  // reset values and counts
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] IDLE_BUS = 8'h00;
  localparam logic [16:0] DIV_ADJ = 17'h00002;
  localparam logic [7:0] TPB_X1 = 8'h01;
  localparam logic [7:0] TPB_X16 = 8'h10;
  localparam logic [7:0] TPB_X32 = 8'h20;
  localparam logic [7:0] TPB_X64 = 8'h40;
  // vector status codes
  localparam logic [2:0] ST_TX = 3'h0;
  localparam logic [2:0] ST_RX = 3'h2;
  localparam logic [2:0] ST_SPEC = 3'h3;
  localparam logic [2:0] ST_NONE = 3'h3;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_t;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_t;
  function automatic logic [7:0] ticks_per_bit(input logic [1:0] m);
    case (m)
      2'h0: ticks_per_bit = TPB_X1;
      2'h1: ticks_per_bit = TPB_X16;
      2'h2: ticks_per_bit = TPB_X32;
      default: ticks_per_bit = TPB_X64;
    endcase
  endfunction : ticks_per_bit
  function automatic logic [3:0] char_bits(input logic [1:0] c);
    case (c)
      2'h0: char_bits = 4'h5;
      2'h1: char_bits = 4'h7;
      2'h2: char_bits = 4'h6;
      default: char_bits = 4'h8;
    endcase
  endfunction : char_bits
  function automatic logic [7:0] stop_ticks(input logic [1:0] c, input logic [7:0] t);
    case (c)
      2'h2: stop_ticks = t + {1'b0, t[7:1]};
      2'h3: stop_ticks = {t[6:0], 1'b0};
      default: stop_ticks = t;
    endcase
  endfunction : stop_ticks
  function automatic logic clk_tick(input logic [1:0] sel, input logic pin, input logic trx, input logic gen);
    case (sel)
      CLK_PIN: clk_tick = pin;
      CLK_TRX: clk_tick = trx;
      default: clk_tick = gen;
    endcase
  endfunction : clk_tick
endpackage : serial_channel_pkg

// ==== verif/host_model.sv ====
// host_model: host bus master for the serial channel
// assumes strobes are sampled through two flops in the device
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic sys_clk_i,
  // bus
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic data_sel_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_sel_o = 1'b0;
    data_o = 8'h00;
  end
  task automatic acc(input logic w, input logic sel, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    data_sel_o <= sel;
    data_o <= d;
    rd_n_o <= w;
    wr_n_o <= ~w;
    repeat (6) @(posedge sys_clk_i);
    // no pull-up on the data bus: an undriven read comes back inverted
    q = data_oe_i ? data_i : ~data_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    // released bus shows no stale value
    data_o <= ~d;
    repeat (8) @(posedge sys_clk_i);
  endtask : acc
  // both strobes low is the reset pin
  task automatic pin_rst;
    @(posedge sys_clk_i);
    rd_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (11) @(posedge sys_clk_i);
  endtask : pin_rst
  task automatic wreg(input logic [7:0] n, input logic [7:0] v);
    logic [7:0] q;
    acc(1'b1, 1'b0, n, q);
    acc(1'b1, 1'b0, v, q);
  endtask : wreg
endmodule : host_model
`default_nettype wire

// ==== verif/tb_async_serial_channel_bringup.sv ====
// tb_async_serial_channel_bringup: loopback bring-up of one channel
// assumes host_model as bus master, pin clock free running
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_channel_bringup
  import serial_channel_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rclk = 1'b0;
  logic cs_n, rd_n, wr_n, dsel, irq_n, tclk_oe, doe, txd, tclk;
  logic [7:0] din, dout, q;
  int errors = 0;
  int n_compared = 0;
  // formats first, enables after, divider 0000
  localparam logic [7:0] INIT [28] = '{8'h09, 8'hC0, 8'h04, 8'h4C, 8'h02, 8'h00, 8'h03, 8'hC0,
    8'h05, 8'h60, 8'h09, 8'h00, 8'h0A, 8'h00, 8'h0B, 8'h56, 8'h0C, 8'h00, 8'h0D, 8'h00,
    8'h0E, 8'h10, 8'h0E, 8'h11, 8'h03, 8'hC1, 8'h05, 8'h68};
  always #50 sys_clk_i = ~sys_clk_i;
  // bit rate far under a quarter of the system clock
  always #200 rclk = ~rclk;
  host_model h (.sys_clk_i(sys_clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .data_sel_o(dsel), .data_o(din), .data_i(dout), .data_oe_i(doe));
  serial_channel uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .data_sel_i(dsel), .data_i(din), .data_o(dout), .data_oe_o(doe),
    .chain_enable_in_i(1'b1), .irq_n_o(irq_n), .rxd_i(1'b1), .txd_o(txd),
    .receive_clock_pin_i(rclk), .transmit_clock_pin_i(1'b0), .transmit_clock_pin_o(tclk),
    .transmit_clock_pin_oe_o(tclk_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_vec(output logic [7:0] v);
    h.acc(1'b1, 1'b0, 8'h02, v);
    h.acc(1'b0, 1'b0, 8'h00, v);
  endtask : rd_vec
  task automatic send_wait(input logic [7:0] c);
    int i;
    h.acc(1'b1, 1'b1, c, q);
    chk({7'h00, txd}, 8'h01);
    q = 8'h00;
    for (i = 0; i < 400 && q[STAT_RXA] !== 1'b1; i++) begin
      h.acc(1'b0, 1'b0, 8'h00, q);
    end
  endtask : send_wait
  task automatic t_reset;
    repeat (11) @(posedge sys_clk_i);
    h.acc(1'b0, 1'b0, 8'h00, q);
    chk(q & 8'h05, 8'h04);
    rd_vec(q);
    chk(q, 8'h06);
    $display("reset test done");
  endtask : t_reset
  task automatic t_loop;
    for (int i = 0; i < 28; i += 2) begin
      h.wreg(INIT[i], INIT[i+1]);
    end
    chk({7'h00, tclk_oe}, 8'h01);
    // generator half period is eight system clocks here
    q = {7'h00, tclk};
    repeat (8) @(posedge sys_clk_i);
    chk({7'h00, tclk}, q ^ 8'h01);
    send_wait(8'hA5);
    chk(q & 8'h05, 8'h05);
    h.acc(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'hA5);
    chk({7'h00, irq_n}, 8'h01);
    $display("loopback test done");
  endtask : t_loop
  task automatic t_irq;
    h.wreg(8'h01, 8'h12);
    h.wreg(8'h09, 8'h08);
    send_wait(8'h3C);
    chk({7'h00, irq_n}, 8'h00);
    rd_vec(q);
    chk(q, 8'h04);
    h.acc(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h3C);
    rd_vec(q);
    chk(q, 8'h00);
    h.acc(1'b1, 1'b0, 8'h28, q);
    chk({7'h00, irq_n}, 8'h01);
    rd_vec(q);
    chk(q, 8'h06);
    h.wreg(8'h09, 8'hC0);
    repeat (11) @(posedge sys_clk_i);
    chk({7'h00, irq_n}, 8'h01);
    chk({7'h00, tclk_oe}, 8'h00);
    rd_vec(q);
    chk(q, 8'h06);
    h.wreg(8'h0B, 8'h56);
    chk({7'h00, tclk_oe}, 8'h01);
    h.pin_rst();
    chk({7'h00, tclk_oe}, 8'h00);
    $display("interrupt test done");
  endtask : t_irq
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_loop();
    t_irq();
    test_done();
  end
  // about 6000 clocks expected
  initial begin
    #5ms;
    errors++;
    test_done();
  end
endmodule : tb_async_serial_channel_bringup
`default_nettype wire
